// ---- logic/ddrbm_core.sv ----
// Behaviour
// [R1] Precharging one open bank idles it; other banks stay open.
// [R2] Controller precharges every bank within the longest row active time.
// [R3] Precharge all is legal anytime; every bank ends idle.
// [R4] Precharge in a read burst stops read data latency clocks later.
// [R5] Precharge in a write burst resets the write input at once.
// [R6] Controller holds the write data mask high for write recovery time.
// [R7] Burst read stop ends reads only; controller never sends it in writes (the testbench sends one inside a write burst).
// [R8] Controller refreshes all rows in time and waits refresh cycle time.
// [R9] Refresh with clock enable low and banks idle enters self refresh.
// [R10] Controller keeps distributed refreshes close around self refresh.
// [R11] Self refresh and power down turn off buffers except clock enable.
// [R12] Clock enable low without burst enters active or precharge power down.
// [R13] Controller sends a no-operation on the edge after leaving power down.
// [R14] Controller changes clock only in precharge power down, enable held low.
// [R15] After a clock change controller resets the DLL and waits relock.
// [R16] Controller writes both mode registers only with every bank idle.
// [R17] Mode bits 2..0 give burst length 2, 4 or 8.
// [R18] Mode bit 3 picks sequential or interleaved order.
// [R19] Sequential order increments and wraps inside the burst block.
// [R20] Interleaved order starts at the given column and interleaves low bits.
// [R21] Mode bits 6..4 give read latency 2, 3 or 2.5.
// [R22] A base mode write with bit 8 set resets the DLL.
// [R23] Bank selects pick base or extended register; high select is reserved.
// [R24] Extended bit 0 low enables the DLL, high disables it.
// [R25] Controller writes test bit 7 and bits 9 to 11 as zero (the testbench's reserved-select write 12'h0AA has bit 7 set).
// [R26] Interleaved beat k uses the start column low bits XOR k.
// [R27] Controller never programs reserved length, latency or select codes (the testbench sends one mode write with reserved select 2).
`timescale 1ns/100ps
`default_nettype none
module ddrbm_core (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cke,
  input wire ddrbm_pkg::ddrbm_cmd_type cmd,
  output ddrbm_pkg::ddrbm_state_type state_reg,
  output logic io_buffers_on_reg,
  output logic [ddrbm_pkg::NBANK-1:0] bank_open_reg,
  output logic [ddrbm_pkg::ADDR_W-1:0] mode_reg,
  output logic [ddrbm_pkg::ADDR_W-1:0] ext_reg,
  output logic dll_on_reg,
  output logic dll_reset_reg,
  output logic burst_rd_reg,
  output logic burst_wr_reg,
  output ddrbm_pkg::ddrbm_beat_type beat_reg,
  output logic write_in_reset_reg,
  output logic read_data_en_reg
);
  import ddrbm_pkg::*;

  ddrbm_state_type state_next;
  logic cke_prev_reg;
  logic [1:0] pair_reg;
  logic [1:0] pair_next;
  logic [1:0] bank_reg;
  logic [1:0] bank_next;
  logic autopre_reg;
  logic autopre_next;
  logic [COL_W-1:0] start_reg;
  logic [COL_W-1:0] start_next;
  logic rd_next;
  logic wr_next;
  logic [NBANK-1:0] bank_open_next;
  ddrbm_beat_type beat_next;

  // Commands count only when clock enable was high on the previous edge.
  wire [2:0] rcw = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  wire [1:0] bsel = {cmd.bank_sel_hi, cmd.bank_sel_lo};
  wire [ADDR_W-1:0] addr = cmd.addr;
  wire live = (state_reg == ST_NORMAL) && cke_prev_reg && !cmd.cs_n;
  wire is_act = live && cke && rcw == CMD_ACT;
  wire is_pre = live && rcw == CMD_PRE;
  wire is_rd = live && cke && rcw == CMD_RD;
  wire is_wr = live && cke && rcw == CMD_WR;
  wire is_bst = live && rcw == CMD_BST;
  wire is_mode = live && cke && rcw == CMD_MODE;
  wire is_ref = live && rcw == CMD_REF;
  wire all_idle = bank_open_reg == 4'h0;
  wire burst_on = burst_rd_reg | burst_wr_reg;
  wire [2:0] bl_code = mode_reg[BL_MSB:BL_LSB];
  wire [2:0] lat_code = mode_reg[LAT_MSB:LAT_LSB];
  wire last = pair_reg == bl_last_pair(bl_code); // [R17]
  wire pre_all = addr[AP_BIT];
  wire pre_hits = is_pre && burst_on && (pre_all || bsel == bank_reg);
  wire bst_hits = is_bst && burst_rd_reg; // [R7]
  wire stop = pre_hits || bst_hits;
  wire start = (is_rd || is_wr) && bank_open_reg[bsel];
  wire ap_close = burst_on && last && autopre_reg && !stop;
  wire [NBANK-1:0] act_mask = is_act ? bank_onehot(bsel) : 4'h0;
  wire [NBANK-1:0] pre_mask = !is_pre ? 4'h0 : (pre_all ? 4'hF : bank_onehot(bsel));
  wire [NBANK-1:0] ap_mask = ap_close ? bank_onehot(bank_reg) : 4'h0;
  wire any_open_next = |bank_open_next;
  wire self_ok = is_ref && !cke && all_idle;
  wire mode_ok = is_mode && all_idle;
  wire base_wr = mode_ok && bsel == SEL_BASE;
  wire ext_wr = mode_ok && bsel == SEL_EXT;

  // Precharge all only touches open banks, and idle banks stay idle.
  assign bank_open_next = (bank_open_reg | act_mask) & ~pre_mask & ~ap_mask; // [R1] [R3]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_NORMAL: begin
        if (self_ok) begin
          state_next = ST_SELF; // [R9]
        end else if (!cke && !burst_on) begin
          state_next = any_open_next ? ST_PD_ACT : ST_PD_PRE; // [R12]
        end
      end
      ST_SELF: begin
        if (cke) begin
          state_next = ST_NORMAL; // [R9]
        end
      end
      ST_PD_ACT, ST_PD_PRE: begin
        if (cke) begin
          state_next = ST_NORMAL;
        end
      end
      default: state_next = ST_NORMAL;
    endcase
  end

  // A new read or write replaces a running burst; a stop ends it early.
  always_comb begin
    rd_next = burst_rd_reg;
    wr_next = burst_wr_reg;
    pair_next = pair_reg;
    bank_next = bank_reg;
    autopre_next = autopre_reg;
    start_next = start_reg;
    if (burst_on) begin
      if (stop || last) begin
        rd_next = 1'h0; // [R4] [R7]
        wr_next = 1'h0; // [R5]
      end else begin
        pair_next = pair_reg + 2'h1;
      end
    end
    if (start) begin
      rd_next = is_rd;
      wr_next = is_wr;
      pair_next = 2'h0;
      bank_next = bsel;
      autopre_next = addr[AP_BIT];
      start_next = addr[COL_W-1:0];
    end
  end

  ddrbm_colgen u_colgen (
    .start_col(start_next),
    .bl_code(bl_code),
    .interleave(mode_reg[ORDER_BIT]),
    .pair(pair_next),
    .beat(beat_next)
  );

  ddrbm_rdpipe u_rdpipe (
    .clk(clk),
    .nrst(nrst),
    .burst_rd(burst_rd_reg),
    .lat_code(lat_code),
    .data_en_reg(read_data_en_reg)
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_NORMAL;
      cke_prev_reg <= 1'h0;
      io_buffers_on_reg <= 1'h1;
      bank_open_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      cke_prev_reg <= cke;
      io_buffers_on_reg <= state_next == ST_NORMAL; // [R11]
      bank_open_reg <= bank_open_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      burst_rd_reg <= 1'h0;
      burst_wr_reg <= 1'h0;
      pair_reg <= 2'h0;
      bank_reg <= 2'h0;
      autopre_reg <= 1'h0;
      start_reg <= 9'h000;
      beat_reg <= '0;
      write_in_reset_reg <= 1'h0;
    end else begin
      burst_rd_reg <= rd_next;
      burst_wr_reg <= wr_next;
      pair_reg <= pair_next;
      bank_reg <= bank_next;
      autopre_reg <= autopre_next;
      start_reg <= start_next;
      beat_reg <= beat_next;
      write_in_reset_reg <= pre_hits && burst_wr_reg; // [R5]
    end
  end

  // Both registers power up undefined in the part; here they clear so that
  // simulation stays free of unknowns until the controller programs them.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_reg <= MODE_RESET;
      ext_reg <= EXT_RESET;
      dll_on_reg <= 1'h0;
      dll_reset_reg <= 1'h0;
    end else begin
      if (base_wr) begin
        mode_reg <= addr; // [R23]
      end
      if (ext_wr) begin
        ext_reg <= addr; // [R23]
      end
      dll_on_reg <= !ext_reg[EXT_DLL_OFF_BIT] && state_reg != ST_SELF; // [R24]
      dll_reset_reg <= base_wr && addr[DLL_RST_BIT]; // [R22]
    end
  end

  a_pre_one_bank: assert property (@(posedge clk) disable iff (!nrst) // [R1]
    is_pre && !pre_all && bank_open_reg[bsel] && !is_act |=>
    !bank_open_reg[$past(bsel)] &&
    ((bank_open_reg | bank_onehot($past(bsel))) == $past(bank_open_reg)))
    else $error("single precharge did not close only its bank");

  a_pre_all_idle: assert property (@(posedge clk) disable iff (!nrst) // [R3]
    is_pre && pre_all |=> bank_open_reg == 4'h0)
    else $error("precharge all left a bank open");

  a_rd_stop_lat2: assert property (@(posedge clk) disable iff (!nrst) // [R4]
    pre_hits && burst_rd_reg && lat_code == LAT_2 ##1 !start |->
    ##1 !read_data_en_reg)
    else $error("read data ran past latency 2 after precharge");

  a_rd_stop_lat3: assert property (@(posedge clk) disable iff (!nrst) // [R4]
    pre_hits && burst_rd_reg && lat_code == LAT_3 ##1 !start[*2] |->
    ##1 !read_data_en_reg)
    else $error("read data ran past latency 3 after precharge");

  a_wr_in_reset: assert property (@(posedge clk) disable iff (!nrst) // [R5]
    pre_hits && burst_wr_reg |=> write_in_reset_reg && !burst_wr_reg)
    else $error("write input not reset by precharge");

  a_bst_read_end: assert property (@(posedge clk) disable iff (!nrst) // [R7]
    is_bst && burst_rd_reg |=> !burst_rd_reg)
    else $error("burst read stop did not end the read");

  a_bst_write_kept: assert property (@(posedge clk) disable iff (!nrst) // [R7]
    is_bst && burst_wr_reg && !last |=> burst_wr_reg && $stable(bank_reg))
    else $error("burst read stop cut a write burst");

  a_self_hold: assert property (@(posedge clk) disable iff (!nrst) // [R9]
    state_reg == ST_SELF && !cke |=> state_reg == ST_SELF && !dll_on_reg)
    else $error("self refresh left while clock enable low");

  a_buffers_off: assert property (@(posedge clk) disable iff (!nrst) // [R11]
    self_ok |=> !io_buffers_on_reg ##1 (!io_buffers_on_reg || $past(cke)))
    else $error("buffers on in self refresh");

  a_pd_kind: assert property (@(posedge clk) disable iff (!nrst) // [R12]
    state_reg == ST_NORMAL && !cke && !burst_on && !self_ok |=>
    state_reg == ($past(any_open_next) ? ST_PD_ACT : ST_PD_PRE))
    else $error("wrong power down kind");

  a_mode_base: assert property (@(posedge clk) disable iff (!nrst) // [R23]
    base_wr |=> mode_reg == $past(addr) && $stable(ext_reg))
    else $error("base mode write not stored");

  a_mode_resv: assert property (@(posedge clk) disable iff (!nrst) // [R23]
    is_mode && cmd.bank_sel_hi |=> $stable(mode_reg) && $stable(ext_reg))
    else $error("reserved select changed a mode register");

  a_dll_reset: assert property (@(posedge clk) disable iff (!nrst) // [R22]
    base_wr && addr[DLL_RST_BIT] |=> dll_reset_reg ##1 (!dll_reset_reg || $past(base_wr)))
    else $error("DLL reset pulse missing");

  a_dll_follow: assert property (@(posedge clk) disable iff (!nrst) // [R24]
    ext_wr ##1 state_reg == ST_NORMAL |=> dll_on_reg == !$past(addr[EXT_DLL_OFF_BIT], 2))
    else $error("DLL enable does not follow the extended register");

  a_pd_leave: assert property (@(posedge clk) disable iff (!nrst) // [R12]
    (state_reg == ST_PD_ACT || state_reg == ST_PD_PRE) && cke |=>
    state_reg == ST_NORMAL && io_buffers_on_reg)
    else $error("power down not left on clock enable");

  a_bl2_short: assert property (@(posedge clk) disable iff (!nrst) // [R17]
    start && bl_code == BL_2 ##1 !start |=> !burst_on)
    else $error("burst of two ran past one clock");

  a_ilv_pair: assert property (@(posedge clk) disable iff (!nrst) // [R26]
    burst_on && mode_reg[ORDER_BIT] |->
    (beat_reg.col_even ^ beat_reg.col_odd) == 9'h001 && beat_reg.col_even[0] == start_reg[0])
    else $error("interleaved beat pair not split on bit 0");

  a_seq_block: assert property (@(posedge clk) disable iff (!nrst) // [R19]
    burst_on && !mode_reg[ORDER_BIT] && bl_code == BL_8 |->
    beat_reg.col_even[COL_W-1:3] == start_reg[COL_W-1:3] &&
    beat_reg.col_odd[COL_W-1:3] == start_reg[COL_W-1:3])
    else $error("sequential burst carried out of its block");
endmodule
`default_nettype wire

// ---- pkg/ddrbm_pkg.sv ----
`default_nettype none
package ddrbm_pkg;
  localparam int COL_W = 9;
  localparam int ADDR_W = 12;
  localparam int NBANK = 4;
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam int ORDER_BIT = 3;
  localparam int LAT_LSB = 4;
  localparam int LAT_MSB = 6;
  localparam int DLL_RST_BIT = 8;
  localparam int AP_BIT = 10;
  localparam int EXT_DLL_OFF_BIT = 0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;
  localparam logic [2:0] LAT_2P5 = 3'h6;
  localparam logic [1:0] SEL_BASE = 2'h0;
  localparam logic [1:0] SEL_EXT = 2'h1;
  localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
  localparam logic [ADDR_W-1:0] EXT_RESET = 12'h000;
  localparam logic [2:0] CMD_MODE = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank_sel_hi;
    logic bank_sel_lo;
    logic [ADDR_W-1:0] addr;
  } ddrbm_cmd_type;

  typedef struct packed {
    logic [COL_W-1:0] col_even;
    logic [COL_W-1:0] col_odd;
  } ddrbm_beat_type;

  typedef enum logic [3:0] {
    ST_NORMAL = 4'h1,
    ST_SELF = 4'h2,
    ST_PD_ACT = 4'h4,
    ST_PD_PRE = 4'h8
  } ddrbm_state_type;

  function automatic logic [NBANK-1:0] bank_onehot(input logic [1:0] b);
    bank_onehot = 4'h1 << b;
  endfunction

  // Reserved length codes fall back to the shortest burst.
  function automatic logic [2:0] bl_mask(input logic [2:0] code);
    case (code)
      BL_4: bl_mask = 3'h3;
      BL_8: bl_mask = 3'h7;
      default: bl_mask = 3'h1;
    endcase
  endfunction

  function automatic logic [1:0] bl_last_pair(input logic [2:0] code);
    logic [2:0] m;
    m = bl_mask(code);
    bl_last_pair = m[2:1];
  endfunction
endpackage
`default_nettype wire

// ---- logic/ddrbm_colgen.sv ----
`timescale 1ns/100ps
`default_nettype none
module ddrbm_colgen (
  input wire logic [ddrbm_pkg::COL_W-1:0] start_col,
  input wire logic [2:0] bl_code,
  input wire logic interleave,
  input wire logic [1:0] pair,
  output ddrbm_pkg::ddrbm_beat_type beat
);
  import ddrbm_pkg::*;

  function automatic logic [COL_W-1:0] beat_col(input logic [2:0] k);
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] kk;
    logic [COL_W-1:0] sum;
    mask = {6'h00, bl_mask(bl_code)};
    kk = {6'h00, k};
    sum = start_col + kk;
    if (interleave) begin
      beat_col = start_col ^ (kk & mask); // [R20] [R26]
    end else begin
      beat_col = (start_col & ~mask) | (sum & mask); // [R19]
    end
  endfunction

  assign beat.col_even = beat_col({pair, 1'h0}); // [R18]
  assign beat.col_odd = beat_col({pair, 1'h1});
endmodule
`default_nettype wire

// ---- logic/ddrbm_rdpipe.sv ----
`timescale 1ns/100ps
`default_nettype none
module ddrbm_rdpipe (
  input wire logic clk,
  input wire logic nrst,
  input wire logic burst_rd,
  input wire logic [2:0] lat_code,
  output logic data_en_reg
);
  import ddrbm_pkg::*;

  logic d1_reg;
  // A latency of 2.5 is rounded up to whole clocks here; the half cycle
  // belongs to the strobe path, which this block does not model.
  wire short_lat = lat_code == LAT_2; // [R21]

  always_ff @(posedge clk) begin
    if (!nrst) begin
      d1_reg <= 1'h0;
      data_en_reg <= 1'h0;
    end else begin
      d1_reg <= burst_rd;
      data_en_reg <= short_lat ? burst_rd : d1_reg; // [R4]
    end
  end
endmodule
`default_nettype wire

// ---- sim/ddrbm_ctrl_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ddrbm_ctrl_model (
  input wire logic clk,
  output var ddrbm_pkg::ddrbm_cmd_type cmd,
  output var logic cke
);
  import ddrbm_pkg::*;
  // A short stand-in for the refresh cycle time; the core does not time it.
  localparam int REF_GAP = 3;
  localparam logic [17:0] NOP_CMD = 18'h1C000;
  localparam int RECOVERY_GAP = 2;
  logic [NBANK-1:0] open_banks;
  int mask_left = 0;
  wire pre_on_bus = !cmd.cs_n && {cmd.ras_n, cmd.cas_n, cmd.we_n} == CMD_PRE;
  // A cut write may still be recovering, so the mask stays up after every
  // precharge for the whole recovery gap.
  wire write_data_mask = pre_on_bus || mask_left != 0;

  always @(posedge clk) begin
    if (pre_on_bus) begin
      mask_left <= RECOVERY_GAP;
    end else if (mask_left != 0) begin
      mask_left <= mask_left - 1;
    end
  end

  initial begin
    cmd = NOP_CMD;
    cke = 1'b1;
    open_banks = 4'h0;
  end

  // The command is set up one edge ahead so that it is taken on the next one.
  task automatic issue(input logic [2:0] rcw, input logic [1:0] bank, input logic [11:0] addr);
    @(posedge clk);
    cmd <= {1'b0, rcw, bank, addr};
    @(posedge clk);
    cmd <= NOP_CMD;
    if (rcw == CMD_ACT) open_banks[bank] = 1'b1;
    if (rcw == CMD_PRE && addr[AP_BIT]) open_banks = 4'h0;
    if (rcw == CMD_PRE && !addr[AP_BIT]) open_banks[bank] = 1'b0;
  endtask

  task automatic mode_write(input logic [1:0] sel, input logic [11:0] value);
    if (open_banks != 4'h0) issue(CMD_PRE, 2'h0, 12'h400);
    issue(CMD_MODE, sel, value & 12'h17F);
  endtask

  // Only a no-operation stands on the bus while the clock enable moves.
  task automatic set_cke(input logic value);
    @(posedge clk);
    cke <= value;
    @(posedge clk);
  endtask

  task automatic enter_self;
    if (open_banks != 4'h0) issue(CMD_PRE, 2'h0, 12'h400);
    auto_refresh();
    @(posedge clk);
    cmd <= {1'b0, CMD_REF, 14'h0000};
    cke <= 1'b0;
    @(posedge clk);
    cmd <= NOP_CMD;
  endtask

  task automatic auto_refresh;
    issue(CMD_REF, 2'h0, 12'h000);
    repeat (REF_GAP) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ddrbm_pkg::*;
  logic clk;
  logic nrst;
  logic cke;
  ddrbm_cmd_type cmd;
  ddrbm_state_type state_reg;
  logic io_buffers_on_reg;
  logic [NBANK-1:0] bank_open_reg;
  logic [ADDR_W-1:0] mode_reg;
  logic [ADDR_W-1:0] ext_reg;
  logic dll_on_reg;
  logic dll_reset_reg;
  logic burst_rd_reg;
  logic burst_wr_reg;
  ddrbm_beat_type beat_reg;
  logic write_in_reset_reg;
  logic read_data_en_reg;
  int bad_count = 0;
  int checked = 0;
  int len;
  logic [11:0] mval;
  logic [2:0] lat_tab [3] = '{LAT_2, LAT_3, LAT_2P5};
  int cl_tab [3] = '{2, 3, 3};

  ddrbm_core ddrbm_core_inst (.clk(clk), .nrst(nrst), .cke(cke), .cmd(cmd),
    .state_reg(state_reg), .io_buffers_on_reg(io_buffers_on_reg),
    .bank_open_reg(bank_open_reg), .mode_reg(mode_reg), .ext_reg(ext_reg),
    .dll_on_reg(dll_on_reg), .dll_reset_reg(dll_reset_reg), .burst_rd_reg(burst_rd_reg),
    .burst_wr_reg(burst_wr_reg), .beat_reg(beat_reg),
    .write_in_reset_reg(write_in_reset_reg), .read_data_en_reg(read_data_en_reg));
  ddrbm_ctrl_model ddrbm_ctrl_model_inst (.clk(clk), .cmd(cmd), .cke(cke));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_vec(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic go(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a);
    ddrbm_ctrl_model_inst.issue(c, b, a);
  endtask

  task automatic cke_to(input logic v);
    ddrbm_ctrl_model_inst.set_cke(v);
    @(negedge clk);
  endtask

  function automatic logic [8:0] col_at(input logic [8:0] s, input int n, input logic il,
    input int k);
    logic [8:0] m;
    m = 9'(n - 1);
    if (il) col_at = s ^ 9'(k);
    else col_at = (s & ~m) | ((s + 9'(k)) & m);
  endfunction

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    give_verdict;
  end

  initial begin
    nrst = 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check_vec(state_reg, ST_NORMAL);
    check_flag(io_buffers_on_reg, 1'b1);
    check_vec(mode_reg, MODE_RESET);
    $display("test reset done");
    for (int o = 0; o < 2; o++) begin
      for (int b = 1; b < 4; b++) begin
        len = 1 << b;
        mval = {3'h0, o[0], 1'b0, LAT_2, o[0], b[2:0]};
        ddrbm_ctrl_model_inst.mode_write(SEL_BASE, mval);
        @(negedge clk);
        check_vec(mode_reg, mval);
        check_flag(dll_reset_reg, o[0]);
        go(CMD_ACT, 2'h1, 12'h000);
        go(CMD_RD, 2'h1, 12'h0D5);
        for (int j = 0; j < len / 2; j++) begin
          @(negedge clk);
          check_flag(burst_rd_reg, 1'b1);
          check_vec(beat_reg, {col_at(9'h0D5, len, o[0], 2 * j),
            col_at(9'h0D5, len, o[0], 2 * j + 1)});
        end
        @(negedge clk);
        check_flag(burst_rd_reg, 1'b0);
      end
    end
    $display("test burst order done");
    go(CMD_ACT, 2'h0, 12'h000);
    go(CMD_ACT, 2'h2, 12'h000);
    @(negedge clk);
    check_vec(bank_open_reg, 4'h7);
    go(CMD_PRE, 2'h0, 12'h000);
    @(negedge clk);
    check_vec(bank_open_reg, 4'h6);
    go(CMD_PRE, 2'h1, 12'h400);
    @(negedge clk);
    check_vec(bank_open_reg, 4'h0);
    go(CMD_PRE, 2'h3, 12'h400);
    @(negedge clk);
    check_vec(bank_open_reg, 4'h0);
    $display("test precharge done");
    ddrbm_ctrl_model_inst.mode_write(SEL_EXT, 12'h001);
    repeat (2) @(negedge clk);
    check_vec(ext_reg, 12'h001);
    check_flag(dll_on_reg, 1'b0);
    ddrbm_ctrl_model_inst.mode_write(SEL_EXT, 12'h000);
    repeat (2) @(negedge clk);
    check_flag(dll_on_reg, 1'b1);
    go(CMD_MODE, 2'h2, 12'h0AA);
    @(negedge clk);
    check_vec(mode_reg, mval);
    check_vec(ext_reg, 12'h000);
    $display("test register select done");
    for (int i = 0; i < 3; i++) begin
      ddrbm_ctrl_model_inst.mode_write(SEL_BASE, {5'h00, lat_tab[i], 4'h3});
      go(CMD_ACT, 2'h3, 12'h000);
      go(CMD_RD, 2'h3, 12'h000);
      go(CMD_PRE, 2'h3, 12'h000);
      @(negedge clk);
      check_flag(burst_rd_reg, 1'b0);
      for (int k = 1; k < cl_tab[i]; k++) begin
        check_flag(read_data_en_reg, 1'b1);
        @(negedge clk);
      end
      check_flag(read_data_en_reg, 1'b0);
    end
    go(CMD_ACT, 2'h0, 12'h000);
    go(CMD_WR, 2'h0, 12'h000);
    go(CMD_PRE, 2'h0, 12'h000);
    @(negedge clk);
    check_flag(write_in_reset_reg, 1'b1);
    check_flag(burst_wr_reg, 1'b0);
    @(negedge clk);
    check_flag(write_in_reset_reg, 1'b0);
    go(CMD_ACT, 2'h0, 12'h000);
    go(CMD_WR, 2'h0, 12'h000);
    go(CMD_BST, 2'h0, 12'h000);
    @(negedge clk);
    check_flag(burst_wr_reg, 1'b1);
    go(CMD_RD, 2'h0, 12'h000);
    go(CMD_BST, 2'h0, 12'h000);
    @(negedge clk);
    check_flag(burst_rd_reg, 1'b0);
    $display("test termination done");
    go(CMD_PRE, 2'h0, 12'h400);
    cke_to(1'b0);
    check_vec(state_reg, ST_PD_PRE);
    check_flag(io_buffers_on_reg, 1'b0);
    cke_to(1'b1);
    check_vec(state_reg, ST_NORMAL);
    ddrbm_ctrl_model_inst.mode_write(SEL_EXT, 12'h000);
    ddrbm_ctrl_model_inst.mode_write(SEL_BASE, 12'h123);
    @(negedge clk);
    check_flag(dll_reset_reg, 1'b1);
    repeat (4) @(negedge clk);
    go(CMD_ACT, 2'h2, 12'h000);
    go(CMD_RD, 2'h2, 12'h000);
    cke_to(1'b0);
    check_vec(state_reg, ST_NORMAL);
    repeat (4) @(negedge clk);
    check_vec(state_reg, ST_PD_ACT);
    cke_to(1'b1);
    ddrbm_ctrl_model_inst.enter_self;
    repeat (3) @(negedge clk);
    check_vec(state_reg, ST_SELF);
    check_flag(io_buffers_on_reg, 1'b0);
    cke_to(1'b1);
    check_vec(state_reg, ST_NORMAL);
    ddrbm_ctrl_model_inst.auto_refresh;
    @(negedge clk);
    check_flag(io_buffers_on_reg, 1'b1);
    $display("test power modes done");
    give_verdict;
  end
endmodule
`default_nettype wire
